// ===== logic/mtx_top.sv
// Summary of operation
// - wake delay holds off transmit after idle exit
// - wake field resets to 1e, top byte reserved
// - idle request follows programmed empty-fifo delay
// - request delay never short, at most 1us long
// - zero request delay requests idle at once
// - fifo refill restarts the request delay
// - deferred counter counts first-attempt deferrals
// - deferrals count only half duplex, no collisions
// - pause counter counts sent pause frames
// - good counter counts ok frames, not undersize
// - counters reset to zero, clear on read
// - counters stop at all ones
// - timing registers only on ports one, two
// - config bit 8 enables energy saving on ports one, two; held zero on port 0
// - test bit makes reads preset 7ffffffc
module mtx_top #(
    parameter logic [2:0] EEE_STRAP = 3'h0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit mac events, one bit per port
    input wire logic [2:0] half_duplex,
    input wire logic [2:0] defer_evt,
    input wire logic [2:0] collision_evt,
    input wire logic [2:0] pause_sent_evt,
    input wire logic [2:0] frame_ok_evt,
    input wire logic [2:0] frame_undersize,
    // energy saving link control, one bit per port
    input wire logic [2:0] tx_fifo_empty,
    output logic [2:0] lpi_request,
    output logic [2:0] tx_hold,
    // transmit configuration toward the mac
    output logic [2:0] tx_enable,
    output logic [2:0] pad_enable,
    output logic [2:0][4:0] ifg_config,
    output logic [2:0] energy_saving_on
);

    // address decode results
    logic [11:0] idx;
    logic aligned;
    logic [2:0] hit_cfg;
    logic [2:0] hit_wake;
    logic [2:0] hit_req;
    logic [2:0] hit_defer;
    logic [2:0] hit_pause;
    logic [2:0] hit_good;
    logic mapped;
    logic [31:0] wmask;
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic rd_setup;

    // register storage
    logic [2:0][8:0] cfg_ff;
    logic [2:0][23:0] wake_ff;
    logic [2:0][31:0] req_ff;
    logic [2:0][31:0] defer_cnt;
    logic [2:0][31:0] pause_cnt;
    logic [2:0][31:0] good_cnt;

    // bus answer state
    logic [31:0] prdata_ff;
    logic err_ff;
    logic [31:0] rd_data;

    // microsecond tick
    logic [6:0] tick_cnt_ff;
    logic us_tick;

    // counter events
    logic [2:0] inc_defer;
    logic [2:0] inc_pause;
    logic [2:0] inc_good;

    // apb phases
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign idx = paddr[13:2];
    assign aligned = (paddr[1:0] == 2'b00);

    // per port register address match
    always_comb
    begin
        for (int p = 0; p < mtx_pkg::NPORT; p++)
        begin
            hit_cfg[p] = aligned && (idx == mtx_pkg::IDX_TX_CFG[p]);
            hit_wake[p] = aligned && mtx_pkg::EEE_PORTS[p] &&
                (idx == mtx_pkg::IDX_WAKE[p]);
            hit_req[p] = aligned && mtx_pkg::EEE_PORTS[p] &&
                (idx == mtx_pkg::IDX_REQ[p]);
            hit_defer[p] = aligned && (idx == mtx_pkg::IDX_DEFER[p]);
            hit_pause[p] = aligned && (idx == mtx_pkg::IDX_PAUSE[p]);
            hit_good[p] = aligned && (idx == mtx_pkg::IDX_GOOD[p]);
        end
    end

    // any register at all answers this address
    assign mapped = |{hit_cfg, hit_wake, hit_req,
        hit_defer, hit_pause, hit_good};

    // byte enables widened to a bit mask
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
        {8{pstrb[1]}}, {8{pstrb[0]}}};

    // writes land on the access edge, reads act on the setup edge
    assign wr_en = access_ph && pwrite && mapped;
    assign rd_setup = setup_ph && !pwrite;

    // read data selection, reserved bits stay zero
    always_comb
    begin
        rd_data = 32'h0;
        for (int p = 0; p < mtx_pkg::NPORT; p++)
        begin
            if (hit_cfg[p])
                rd_data = {23'h0, cfg_ff[p]};
            if (hit_wake[p])
                rd_data = {8'h00, wake_ff[p]};
            if (hit_req[p])
                rd_data = req_ff[p];
            if (hit_defer[p])
                rd_data = defer_cnt[p];
            if (hit_pause[p])
                rd_data = pause_cnt[p];
            if (hit_good[p])
                rd_data = good_cnt[p];
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0;
        else if (rd_setup)
            prdata_ff <= rd_data;
    end

    // unmapped or unaligned addresses answer with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_ff <= 1'b0;
        else if (setup_ph)
            err_ff <= !mapped;
    end

    // zero wait state answer
    assign pready = access_ph;
    assign pslverr = access_ph && err_ff;
    assign prdata = prdata_ff;

    // free running microsecond tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_ff <= 7'h00;
        else if (tick_cnt_ff == 7'(mtx_pkg::TICK_CYCLES - 1))
            tick_cnt_ff <= 7'h00;
        else
            tick_cnt_ff <= tick_cnt_ff + 7'h01;
    end

    assign us_tick = (tick_cnt_ff == 7'(mtx_pkg::TICK_CYCLES - 1));

    // per port configuration, timing, counters and idle sequencer
    generate
        for (genvar p = 0; p < mtx_pkg::NPORT; p++)
        begin : g_port
            logic [31:0] cfg_new;
            logic [31:0] wake_new;
            logic [31:0] req_new;
            logic rd_defer;
            logic rd_pause;
            logic rd_good;
            logic test_on;

            // reset value with the eee strap merged in, port 0 never
            localparam logic [8:0] CFG_RST_P = mtx_pkg::CFG_RST |
                ((p != 0 && EEE_STRAP[p]) ?
                9'(1 << mtx_pkg::CFG_EEE_BIT) : 9'h000);

            // byte-lane merge of write data
            assign cfg_new = (pwdata & wmask) |
                ({23'h0, cfg_ff[p]} & ~wmask);
            assign wake_new = (pwdata & wmask) |
                ({8'h00, wake_ff[p]} & ~wmask);
            assign req_new = (pwdata & wmask) | (req_ff[p] & ~wmask);

            // transmit configuration register
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg_ff[p] <= CFG_RST_P;
                else if (wr_en && hit_cfg[p])
                begin
                    cfg_ff[p] <= cfg_new[8:0];
                    if (p == 0)
                        cfg_ff[p][mtx_pkg::CFG_EEE_BIT] <= 1'b0;
                end
            end

            // wake delay, only the low 24 bits are kept
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    wake_ff[p] <= mtx_pkg::WAKE_RST;
                else if (wr_en && hit_wake[p])
                    wake_ff[p] <= wake_new[23:0];
            end

            // idle request delay
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    req_ff[p] <= mtx_pkg::REQ_RST;
                else if (wr_en && hit_req[p])
                    req_ff[p] <= req_new;
            end

            // configuration outputs
            assign tx_enable[p] = cfg_ff[p][mtx_pkg::CFG_TXEN_BIT];
            assign pad_enable[p] = cfg_ff[p][mtx_pkg::CFG_PAD_BIT];
            assign ifg_config[p] =
                cfg_ff[p][mtx_pkg::CFG_IFG_MSB:mtx_pkg::CFG_IFG_LSB];
            assign energy_saving_on[p] =
                cfg_ff[p][mtx_pkg::CFG_EEE_BIT];
            assign test_on = cfg_ff[p][mtx_pkg::CFG_TEST_BIT];

            // counter events from the transmit mac
            assign inc_defer[p] = defer_evt[p] && half_duplex[p] &&
                !collision_evt[p];
            assign inc_pause[p] = pause_sent_evt[p];
            assign inc_good[p] = frame_ok_evt[p] &&
                !frame_undersize[p];

            // clearing reads happen together with data capture
            assign rd_defer = rd_setup && hit_defer[p];
            assign rd_pause = rd_setup && hit_pause[p];
            assign rd_good = rd_setup && hit_good[p];

            mtx_sat_counter #(
                .WIDTH(mtx_pkg::DATA_W)
            ) u_defer (
                .pclk(pclk),
                .presetn(presetn),
                .inc(inc_defer[p]),
                .rd_clr(rd_defer),
                .test_mode(test_on),
                .count_ff(defer_cnt[p])
            );

            mtx_sat_counter #(
                .WIDTH(mtx_pkg::DATA_W)
            ) u_pause (
                .pclk(pclk),
                .presetn(presetn),
                .inc(inc_pause[p]),
                .rd_clr(rd_pause),
                .test_mode(test_on),
                .count_ff(pause_cnt[p])
            );

            mtx_sat_counter #(
                .WIDTH(mtx_pkg::DATA_W)
            ) u_good (
                .pclk(pclk),
                .presetn(presetn),
                .inc(inc_good[p]),
                .rd_clr(rd_good),
                .test_mode(test_on),
                .count_ff(good_cnt[p])
            );

            // idle sequencing exists only where the timing registers do
            if (mtx_pkg::EEE_PORTS[p])
            begin : g_eee
                mtx_eee_timer u_timer (
                    .pclk(pclk),
                    .presetn(presetn),
                    .eee_on(energy_saving_on[p]),
                    .us_tick(us_tick),
                    .fifo_empty(tx_fifo_empty[p]),
                    .wake_delay(wake_ff[p]),
                    .req_delay(req_ff[p]),
                    .lpi_request(lpi_request[p]),
                    .tx_hold(tx_hold[p])
                );
            end
            else
            begin : g_no_eee
                // port 0 never enters low power idle
                assign lpi_request[p] = 1'b0;
                assign tx_hold[p] = 1'b0;
            end
        end
    endgenerate

endmodule // mtx_top

// ===== include/mtx_pkg.sv
// shared constants for the transmit eee timing and statistics block
package mtx_pkg;

    // apb geometry
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int NPORT = 3;

    // microsecond tick derived from the bus clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 7;

    // register indices per port, byte address is four times the index
    localparam logic [2:0][11:0] IDX_TX_CFG = {12'hc40, 12'h840, 12'h440};
    localparam logic [2:0][11:0] IDX_WAKE = {12'hc42, 12'h842, 12'h000};
    localparam logic [2:0][11:0] IDX_REQ = {12'hc43, 12'h843, 12'h000};
    localparam logic [2:0][11:0] IDX_DEFER = {12'hc51, 12'h851, 12'h451};
    localparam logic [2:0][11:0] IDX_PAUSE = {12'hc52, 12'h852, 12'h452};
    localparam logic [2:0][11:0] IDX_GOOD = {12'hc53, 12'h853, 12'h453};
    // ports that carry the two eee timing registers
    localparam logic [2:0] EEE_PORTS = 3'h6;

    // transmit configuration fields
    localparam int CFG_TXEN_BIT = 0;
    localparam int CFG_PAD_BIT = 1;
    localparam int CFG_IFG_LSB = 2;
    localparam int CFG_IFG_MSB = 6;
    localparam int CFG_TEST_BIT = 7;
    localparam int CFG_EEE_BIT = 8;
    localparam int CFG_W = 9;
    localparam logic [8:0] CFG_RST = 9'h057;

    // timing registers
    localparam int WAKE_W = 24;
    localparam logic [23:0] WAKE_RST = 24'h00001e;
    localparam logic [31:0] REQ_RST = 32'h00000000;

    // statistics counters
    localparam logic [31:0] CNT_RST = 32'h00000000;
    localparam logic [31:0] CNT_TEST = 32'h7ffffffc;

    // low power idle sequencing
    typedef enum logic [1:0]
    {
        MTX_ST_ACTIVE = 2'b00,
        MTX_ST_WAIT = 2'b01,
        MTX_ST_LPI = 2'b10,
        MTX_ST_WAKE = 2'b11
    } mtx_eee_state_e;

endpackage

// ===== logic/mtx_sat_counter.sv
// saturating statistics counter, cleared or preset when software reads it
module mtx_sat_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // count event and read side effect
    input wire logic inc,
    input wire logic rd_clr,
    input wire logic test_mode,
    // current value
    output logic [WIDTH-1:0] count_ff
);

    logic [WIDTH-1:0] base;
    logic [WIDTH-1:0] nxt_count;

    // a read restarts from zero or the test value, an increment then adds
    always_comb
    begin
        if (rd_clr)
            base = test_mode ? mtx_pkg::CNT_TEST[WIDTH-1:0] : '0;
        else
            base = count_ff;
        if (inc && (base != {WIDTH{1'b1}}))
            nxt_count = base + 1'b1;
        else
            nxt_count = base;
    end

    // counter state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_ff <= mtx_pkg::CNT_RST[WIDTH-1:0];
        else
            count_ff <= nxt_count;
    end

endmodule // mtx_sat_counter

// ===== logic/mtx_eee_timer.sv
// per port low power idle request delay and wake hold-off sequencer
module mtx_eee_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic eee_on,
    input wire logic us_tick,
    input wire logic fifo_empty,
    input wire logic [23:0] wake_delay,
    input wire logic [31:0] req_delay,
    // toward the phy and the transmit path
    output logic lpi_request,
    output logic tx_hold
);

    mtx_pkg::mtx_eee_state_e state_ff;
    mtx_pkg::mtx_eee_state_e nxt_state;
    logic [31:0] us_cnt_ff;
    logic clr_cnt;
    logic req_done;
    logic wake_done;

    // ticks seen exceed the delay, so the wait is never short, at most 1 us long
    assign req_done = (req_delay == 32'h0) || (us_cnt_ff > req_delay);
    assign wake_done = (wake_delay == 24'h0) ||
        (us_cnt_ff > {8'h00, wake_delay});

    // state sequencing
    always_comb
    begin
        nxt_state = state_ff;
        clr_cnt = 1'b0;
        case (state_ff)
            mtx_pkg::MTX_ST_ACTIVE:
            begin
                clr_cnt = 1'b1;
                if (fifo_empty)
                    nxt_state = (req_delay == 32'h0) ?
                        mtx_pkg::MTX_ST_LPI : mtx_pkg::MTX_ST_WAIT;
            end
            mtx_pkg::MTX_ST_WAIT:
            begin
                if (!fifo_empty)
                    nxt_state = mtx_pkg::MTX_ST_ACTIVE;
                else if (req_done)
                    nxt_state = mtx_pkg::MTX_ST_LPI;
            end
            mtx_pkg::MTX_ST_LPI:
            begin
                clr_cnt = 1'b1;
                if (!fifo_empty)
                    nxt_state = mtx_pkg::MTX_ST_WAKE;
            end
            mtx_pkg::MTX_ST_WAKE:
            begin
                if (wake_done)
                    nxt_state = mtx_pkg::MTX_ST_ACTIVE;
            end
            default:
            begin
                nxt_state = mtx_pkg::MTX_ST_ACTIVE;
            end
        endcase
        if (!eee_on)
            nxt_state = mtx_pkg::MTX_ST_ACTIVE;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= mtx_pkg::MTX_ST_ACTIVE;
        else
            state_ff <= nxt_state;
    end

    // microsecond tick counter, saturating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            us_cnt_ff <= 32'h0;
        else if (clr_cnt)
            us_cnt_ff <= 32'h0;
        else if (us_tick && (us_cnt_ff != 32'hffffffff))
            us_cnt_ff <= us_cnt_ff + 32'h1;
    end

    // outputs straight from state
    assign lpi_request = (state_ff == mtx_pkg::MTX_ST_LPI);
    assign tx_hold = (state_ff == mtx_pkg::MTX_ST_LPI) ||
        (state_ff == mtx_pkg::MTX_ST_WAKE);

endmodule // mtx_eee_timer

// ===== tb/mtx_top_monitor.sv
// apb handshake and energy saving link checks on the top ports
module mtx_top_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // energy saving link control
    input wire logic [2:0] tx_fifo_empty,
    input wire logic [2:0] lpi_request,
    input wire logic [2:0] tx_hold,
    input wire logic [2:0] energy_saving_on
);
    timeunit 1ns;
    timeprecision 1ps;

    // one clock domain for every check
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answers in the cycle after setup
    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_error_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access cycle");
    // port zero has no timing registers
    a_port0_quiet: assert property (!lpi_request[0] && !tx_hold[0])
        else $error("port zero left active idle");
    // link idle always blocks frame starts
    a_lpi_holds: assert property ((lpi_request & ~tx_hold) == 3'h0)
        else $error("idle request without hold");
    a_disable_idles: assert property
        (!energy_saving_on[1] |=> !lpi_request[1] && !tx_hold[1])
        else $error("idle kept after disable");
    a_lpi_from_empty: assert property
        ($rose(lpi_request[1]) |->
         $past(tx_fifo_empty[1]) && $past(energy_saving_on[1]))
        else $error("idle request without empty fifo");
    a_refill_restart: assert property
        (!tx_fifo_empty[1] && !lpi_request[1] |=> !lpi_request[1])
        else $error("idle requested with data queued");
    a_wake_holds: assert property
        (lpi_request[1] && !tx_fifo_empty[1] && energy_saving_on[1]
         |=> !lpi_request[1] && tx_hold[1])
        else $error("wake did not hold transmit");
endmodule // mtx_top_monitor

bind mtx_top mtx_top_monitor u_mtx_top_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .tx_fifo_empty(tx_fifo_empty),
    .lpi_request(lpi_request), .tx_hold(tx_hold),
    .energy_saving_on(energy_saving_on)
);

// ===== tb/mtx_phy_model.sv
// fabric side transmit fifo feeding the mac of each port
module mtx_phy_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // queue one frame of four words per bit
    input wire logic [2:0] load,
    // frame start permission from the mac
    input wire logic [2:0] tx_hold,
    // fifo state toward the mac
    output logic [2:0] tx_fifo_empty
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] fill_ff [3];

    // words leave only while the mac allows a frame start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fill_ff <= '{default: 4'h0};
        else
            for (int p = 0; p < 3; p++)
                if (load[p])
                    fill_ff[p] <= fill_ff[p] + 4'h4;
                else if (fill_ff[p] != 4'h0 && !tx_hold[p])
                    fill_ff[p] <= fill_ff[p] - 4'h1;
    end

    // empty flag follows the fill level
    always_comb
    begin
        for (int p = 0; p < 3; p++)
            tx_fifo_empty[p] = (fill_ff[p] == 4'h0);
    end
endmodule // mtx_phy_model

// ===== tb/mtx_top_tb.sv
// self-checking bench for the transmit timing and statistics block
module mtx_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic wr;
        logic [11:0] idx;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } mtx_row_s;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] half_duplex, defer_evt, collision_evt, pause_sent_evt;
    logic [2:0] frame_ok_evt, frame_undersize, tx_fifo_empty, load;
    logic [2:0] lpi_request, tx_hold, tx_enable, pad_enable;
    logic [2:0] energy_saving_on;
    logic [2:0][4:0] ifg_config;
    int err_count = 0;
    int num_checks = 0;
    int n;

    // register accesses after the event burst, reads carry expectations
    mtx_row_s rows [12] = '{
        '{1'b0, 12'h842, 32'h0, 32'h1e, 1'b0},
        '{1'b0, 12'hc42, 32'h0, 32'h1e, 1'b0},
        '{1'b0, 12'h843, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h440, 32'h0, 32'h57, 1'b0},
        '{1'b0, 12'h451, 32'h0, 32'h2, 1'b0},
        '{1'b0, 12'h453, 32'h0, 32'h1, 1'b0},
        '{1'b0, 12'h451, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h442, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h842, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, 12'h842, 32'h0, 32'h00ffffff, 1'b0},
        '{1'b1, 12'h851, 32'h5, 32'h0, 1'b0},
        '{1'b0, 12'h851, 32'h0, 32'h2, 1'b0}
    };

    // 100 MHz bus clock
    always #5 pclk = ~pclk;

    mtx_top #(.EEE_STRAP(3'h0)) u_mtx_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .half_duplex(half_duplex), .defer_evt(defer_evt),
        .collision_evt(collision_evt), .pause_sent_evt(pause_sent_evt),
        .frame_ok_evt(frame_ok_evt), .frame_undersize(frame_undersize),
        .tx_fifo_empty(tx_fifo_empty), .lpi_request(lpi_request),
        .tx_hold(tx_hold), .tx_enable(tx_enable), .pad_enable(pad_enable),
        .ifg_config(ifg_config), .energy_saving_on(energy_saving_on)
    );

    mtx_phy_model u_mtx_phy_model (
        .pclk(pclk), .presetn(presetn), .load(load), .tx_hold(tx_hold),
        .tx_fifo_empty(tx_fifo_empty)
    );

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; pev pulses pause events during the setup cycle
    task automatic apb(input logic wr, input logic [11:0] idx,
        input logic [31:0] d, input logic [2:0] pev,
        output logic [31:0] data, output logic err);
        int w;
        w = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pause_sent_evt <= pev;
        @(posedge pclk);
        penable <= 1'b1;
        pause_sent_evt <= 3'h0;
        do
        begin
            @(posedge pclk);
            w++;
        end
        while (pready !== 1'b1 && w < 20);
        if (w >= 20)
            err_count++;
        data = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // pulse a set of mac events on all ports, reps times
    task automatic evt(input logic [4:0] v, input int reps);
        repeat (reps)
        begin
            defer_evt <= {3{v[4]}};
            collision_evt <= {3{v[3]}};
            pause_sent_evt <= {3{v[2]}};
            frame_ok_evt <= {3{v[1]}};
            frame_undersize <= {3{v[0]}};
            @(posedge pclk);
            {defer_evt, collision_evt, pause_sent_evt} <= 9'h0;
            {frame_ok_evt, frame_undersize} <= 6'h0;
            @(posedge pclk);
        end
    endtask

    // count cycles until lpi (0), hold (1) or empty (2) of port p is v
    task automatic wait_bit(input int sel, input int p, input logic v,
        output int cnt);
        cnt = 0;
        do
        begin
            @(negedge pclk);
            cnt++;
        end
        while ((sel == 0 ? lpi_request[p] : sel == 1 ? tx_hold[p] :
            tx_fifo_empty[p]) !== v && cnt < 5000);
        if (cnt >= 5000)
            err_count++;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {psel, penable, pwrite, load} <= 6'h0;
        paddr <= 14'h0;
        pwdata <= 32'h0;
        half_duplex <= 3'h7;
        {defer_evt, collision_evt, pause_sent_evt} <= 9'h0;
        {frame_ok_evt, frame_undersize} <= 6'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("config reset", {8'h0, tx_enable, pad_enable, energy_saving_on,
            ifg_config}, {8'h0, 3'h7, 3'h7, 3'h0, {3{5'h15}}});
        evt(5'h10, 2);
        evt(5'h18, 1);
        half_duplex <= 3'h0;
        evt(5'h10, 1);
        half_duplex <= 3'h7;
        evt(5'h06, 1);
        evt(5'h03, 1);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].idx, rows[i].d, 3'h0, rd, er);
            if (!rows[i].wr)
                chk("read data", rd, rows[i].exp);
            chk("error flag", {31'h0, er}, {31'h0, rows[i].err});
        end
        // increment on the clearing read, then counter test preset
        apb(1'b0, 12'h852, 32'h0, 3'h2, rd, er);
        chk("pause count", rd, 32'h1);
        apb(1'b0, 12'h852, 32'h0, 3'h0, rd, er);
        chk("pause kept", rd, 32'h1);
        apb(1'b1, 12'h840, 32'hd7, 3'h0, rd, er);
        apb(1'b0, 12'h852, 32'h0, 3'h0, rd, er);
        apb(1'b0, 12'h852, 32'h0, 3'h0, rd, er);
        chk("test preset", rd, 32'h7ffffffc);
        // delays programmed while saving is off, then enabled
        apb(1'b1, 12'h842, 32'h1e, 3'h0, rd, er);
        apb(1'b1, 12'h843, 32'h2, 3'h0, rd, er);
        apb(1'b1, 12'h840, 32'h157, 3'h0, rd, er);
        repeat (150) @(posedge pclk);
        load <= 3'h2;
        @(posedge pclk);
        load <= 3'h0;
        wait_bit(2, 1, 1'b1, n);
        wait_bit(0, 1, 1'b1, n);
        chk("request delay", {31'h0, n >= 200 && n <= 305}, 32'h1);
        load <= 3'h2;
        @(posedge pclk);
        load <= 3'h0;
        wait_bit(0, 1, 1'b0, n);
        wait_bit(1, 1, 1'b0, n);
        chk("wake hold", {31'h0, n >= 3000 && n <= 3105}, 32'h1);
        apb(1'b1, 12'h840, 32'h57, 3'h0, rd, er);
        apb(1'b1, 12'hc43, 32'h0, 3'h0, rd, er);
        apb(1'b1, 12'hc40, 32'h157, 3'h0, rd, er);
        wait_bit(0, 2, 1'b1, n);
        chk("zero delay", {31'h0, n <= 3}, 32'h1);
        // reset in mid-run returns links, config and counters to reset
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("idle in reset", {26'h0, lpi_request, tx_hold}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("config again", {8'h0, tx_enable, pad_enable, energy_saving_on,
            ifg_config}, {8'h0, 3'h7, 3'h7, 3'h0, {3{5'h15}}});
        apb(1'b0, 12'h852, 32'h0, 3'h0, rd, er);
        chk("count after reset", rd, 32'h0);
        apb(1'b0, 12'h842, 32'h0, 3'h0, rd, er);
        chk("wake after reset", rd, 32'h1e);
        report_and_stop();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end
endmodule // mtx_top_tb
